// File: logic/qinq_pkg.sv
/*
 * Package for the QinQ tag processor: register map, field positions,
 * reset values, timer limits and the carrier structs.
 * Assumes a single switch clock of 25 MHz and a 32-bit APB register bus.
 */
`default_nettype none
package qinq_pkg;
    // Port count and widths
    localparam int NPORT = 4;
    localparam int PW = 2;
    localparam int VW = 12;
    // Standard tag ethertype and the fixed dummy inner tag control word
    localparam logic [15:0] STD_TPID = 16'h8100;
    localparam logic [15:0] DUMMY_TCI = 16'h0000;
    // Register offsets: per-port block at PORT_BASE + 16*port
    localparam logic [11:0] OFF_VTABLE = 12'h000;   // write: index, valid, members, untagged
    localparam logic [11:0] OFF_VREAD = 12'h004;    // read: entry at last written index
    localparam logic [11:0] OFF_STATUS = 12'h008;   // frame and drop counters
    localparam logic [11:0] OFF_PORT_BASE = 12'h100;
    localparam logic [11:0] OFF_P_CFG = 12'h000;    // port_default_vlan_id, mode, tunnel mode, filter
    localparam logic [11:0] OFF_P_TPID = 12'h004;
    localparam logic [11:0] OFF_P_JOIN = 12'h008;
    localparam logic [11:0] OFF_P_LEAVE = 12'h00c;  // leave [15:0], leaveall [31:16]
    // Field positions in the port config word
    localparam int F_PORT_DEFAULT_VLAN_ID = 0;
    localparam int F_MODE = 12;
    localparam int F_TUN = 14;
    localparam int F_FILT = 16;
    // Reset values
    localparam logic [VW-1:0] RST_PORT_DEFAULT_VLAN_ID = 12'h001;
    localparam logic [15:0] RST_JOIN = 16'd20;
    localparam logic [15:0] RST_LEAVE = 16'd60;
    localparam logic [15:0] RST_LEAVEALL = 16'd1000;
    // Timer limits in centiseconds
    localparam logic [15:0] JOIN_MIN = 16'd20;
    localparam logic [15:0] JOIN_MAX = 16'd1000;
    localparam logic [15:0] LEAVE_MIN = 16'd60;
    localparam logic [15:0] LEAVE_MAX = 16'd3000;
    localparam logic [15:0] LALL_MIN = 16'd500;
    localparam logic [15:0] LALL_MAX = 16'd18000;
    // Timer tick: 10 ms at 25 MHz
    localparam int CLK_HZ = 25000000;
    localparam int TICK_MS = 10;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;

    typedef enum logic [1:0] {
        MODE_HYBRID = 2'b00,
        MODE_ACCESS = 2'b01,
        MODE_TRUNK = 2'b10
    } member_mode_t;

    typedef enum logic [1:0] {
        TUN_NORMAL = 2'b00,
        TUN_ACCESS = 2'b01,
        TUN_UPLINK = 2'b10
    } tunnel_mode_t;

    // Parsed header of a received frame: up to two tags
    typedef struct packed {
        logic [PW-1:0] port;
        logic [15:0] type1;
        logic [15:0] tci1;
        logic [15:0] type2;
        logic [15:0] tci2;
        logic da_hit;
    } rx_hdr_t;

    // Classified frame for the switching core
    typedef struct packed {
        logic drop;
        logic flood;
        logic [PW-1:0] port;
        logic [15:0] outer_type;
        logic [15:0] outer_tci;
        logic inner_valid;
        logic [15:0] inner_type;
        logic [15:0] inner_tci;
        logic [NPORT-1:0] dest;
    } cls_t;

    // Egress request and the tag decision
    typedef struct packed {
        logic [PW-1:0] port;
        logic [VW-1:0] vid;
        logic two_tags;
    } eg_req_t;

    typedef struct packed {
        logic keep_outer;
        logic keep_inner;
    } eg_res_t;
endpackage
`default_nettype wire

// File: logic/qinq_tag_proc.sv
/*
 * QinQ VLAN tag processor: ingress classification and outer-tag insert,
 * drop/flood decisions, egress tag strip, per-port config and GARP timers.
 * Assumes header fields already parsed by the port MAC and lookup results
 * supplied by the address tables; one clock, APB slave for configuration.
 */
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module qinq_tag_proc
    import qinq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_valid,
    input wire rx_hdr_t rx_hdr,
    output cls_t cls_out,
    output logic cls_valid,
    input wire logic eg_valid,
    input wire eg_req_t eg_req,
    output eg_res_t eg_res,
    output logic eg_res_valid,
    output logic [NPORT-1:0] join_expired,
    output logic [NPORT-1:0] leave_expired,
    output logic [NPORT-1:0] leaveall_expired
);
    // VLAN table: valid, member ports, untagged ports
    logic [4095:0] vt_valid_reg;
    logic [NPORT-1:0] vt_mem_reg [4096];
    logic [NPORT-1:0] vt_untag_reg [4096];
    logic [VW-1:0] vt_idx_reg;
    // Per-port configuration
    logic [VW-1:0] port_default_vlan_id_reg [NPORT];
    member_mode_t mmode_reg [NPORT];
    tunnel_mode_t tmode_reg [NPORT];
    logic [NPORT-1:0] filt_reg;
    logic [15:0] tpid_reg [NPORT];
    logic [15:0] join_reg [NPORT];
    logic [15:0] leave_reg [NPORT];
    logic [15:0] lall_reg [NPORT];
    logic [15:0] rx_cnt_reg;
    logic [15:0] drop_cnt_reg;
    logic [NPORT-1:0] vmem;
    logic [NPORT-1:0] vuntag;

    // Clamp a timer write into its legal range
    function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
        if (v < lo) begin
            return lo;
        end else if (v > hi) begin
            return hi;
        end
        return v;
    endfunction

    // Decode the port index of a per-port register address
    function automatic logic [PW-1:0] port_of(input logic [11:0] a);
        return a[4+PW-1:4];
    endfunction

    logic acc;
    logic wr;
    logic in_port;
    logic [11:0] poff;
    assign acc = psel && penable && clk_en;
    assign wr = acc && pwrite;
    assign in_port = (paddr >= OFF_PORT_BASE) && (paddr < OFF_PORT_BASE + 12'(16 * NPORT));
    assign poff = {8'h00, paddr[3:0]};

    // Per-port configuration writes; timers are clamped to their ranges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NPORT; i++) begin
                port_default_vlan_id_reg[i] <= RST_PORT_DEFAULT_VLAN_ID;
                mmode_reg[i] <= MODE_HYBRID;
                tmode_reg[i] <= TUN_NORMAL;
                tpid_reg[i] <= STD_TPID;
                join_reg[i] <= RST_JOIN;
                leave_reg[i] <= RST_LEAVE;
                lall_reg[i] <= RST_LEAVEALL;
            end
            filt_reg <= '1;
        end else if (wr && in_port) begin
            unique case (poff)
                OFF_P_CFG: begin
                    port_default_vlan_id_reg[port_of(paddr)] <= pwdata[F_PORT_DEFAULT_VLAN_ID +: VW];
                    mmode_reg[port_of(paddr)] <= member_mode_t'(pwdata[F_MODE +: 2]);
                    tmode_reg[port_of(paddr)] <= tunnel_mode_t'(pwdata[F_TUN +: 2]);
                    filt_reg[port_of(paddr)] <= pwdata[F_FILT];
                end
                OFF_P_TPID: tpid_reg[port_of(paddr)] <= pwdata[15:0];
                OFF_P_JOIN: begin
                    join_reg[port_of(paddr)] <= clamp(pwdata[15:0], JOIN_MIN, JOIN_MAX);
                end
                OFF_P_LEAVE: begin
                    leave_reg[port_of(paddr)] <= clamp(pwdata[15:0], LEAVE_MIN, LEAVE_MAX);
                    lall_reg[port_of(paddr)] <= clamp(pwdata[31:16], LALL_MIN, LALL_MAX);
                end
                default: ;
            endcase
        end
    end

    // VLAN table writes; no reset on the arrays to keep them RAM-like,
    // the valid bits and the read index are cleared so stale entries never match
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vt_valid_reg <= '0;
            vt_idx_reg <= '0;
        end else if (wr && paddr == OFF_VTABLE) begin
            vt_idx_reg <= pwdata[VW-1:0];
            vt_valid_reg[pwdata[VW-1:0]] <= pwdata[12];
        end
    end

    always_ff @(posedge pclk) begin
        if (wr && paddr == OFF_VTABLE) begin
            vt_mem_reg[pwdata[VW-1:0]] <= pwdata[16 +: NPORT];
            vt_untag_reg[pwdata[VW-1:0]] <= pwdata[24 +: NPORT];
        end
    end

    // APB answer: zero wait states, error on unmapped addresses outside the per-port blocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !(in_port || paddr == OFF_VTABLE ||
                       paddr == OFF_VREAD || paddr == OFF_STATUS);
            prdata <= '0;
            if (psel && !penable && !pwrite) begin
                if (paddr == OFF_VREAD) begin
                    prdata <= {4'h0, vt_untag_reg[vt_idx_reg], 4'h0, vt_mem_reg[vt_idx_reg],
                               3'b000, vt_valid_reg[vt_idx_reg], vt_idx_reg};
                end else if (paddr == OFF_STATUS) begin
                    prdata <= {drop_cnt_reg, rx_cnt_reg};
                end else if (in_port) begin
                    unique case (poff)
                        OFF_P_CFG: prdata <= {15'h0, filt_reg[port_of(paddr)],
                                              tmode_reg[port_of(paddr)],
                                              mmode_reg[port_of(paddr)],
                                              port_default_vlan_id_reg[port_of(paddr)]};
                        OFF_P_TPID: prdata <= {16'h0, tpid_reg[port_of(paddr)]};
                        OFF_P_JOIN: prdata <= {16'h0, join_reg[port_of(paddr)]};
                        OFF_P_LEAVE: prdata <= {lall_reg[port_of(paddr)],
                                                leave_reg[port_of(paddr)]};
                        default: prdata <= '0;
                    endcase
                end
            end
        end
    end

    // Ingress classification, combinational from the parsed header
    cls_t cls_next;
    logic [15:0] ptpid;
    logic [VW-1:0] ppvid;
    logic t1_std;
    logic t1_port;
    logic t2_std;
    logic has_tag;
    always_comb begin
        ptpid = tpid_reg[rx_hdr.port];
        ppvid = port_default_vlan_id_reg[rx_hdr.port];
        t1_port = rx_hdr.type1 == ptpid;
        t1_std = rx_hdr.type1 == STD_TPID;
        t2_std = rx_hdr.type2 == STD_TPID;
        has_tag = t1_port || t1_std;
        cls_next = '0;
        cls_next.port = rx_hdr.port;
        cls_next.outer_type = ptpid;
        cls_next.outer_tci = {3'b000, 1'b0, ppvid};
        unique case (tmode_reg[rx_hdr.port])
            TUN_ACCESS: begin
                // Every frame counts as tagged and gets a new outer tag
                cls_next.inner_valid = 1'b1;
                if (has_tag) begin
                    cls_next.outer_tci[15:13] = rx_hdr.tci1[15:13];
                    cls_next.inner_type = rx_hdr.type1;
                    cls_next.inner_tci = rx_hdr.tci1;
                end else begin
                    cls_next.inner_type = STD_TPID;
                    cls_next.inner_tci = DUMMY_TCI;
                end
            end
            TUN_UPLINK: begin
                if (t1_port) begin
                    // Outer tag already service-provider: keep it
                    cls_next.outer_type = rx_hdr.type1;
                    cls_next.outer_tci = rx_hdr.tci1;
                    cls_next.inner_valid = t2_std;
                    cls_next.inner_type = rx_hdr.type2;
                    cls_next.inner_tci = rx_hdr.tci2;
                end else if (t1_std) begin
                    // Customer tag: prepend outer tag, frame is double
                    cls_next.inner_valid = 1'b1;
                    cls_next.inner_type = rx_hdr.type1;
                    cls_next.inner_tci = rx_hdr.tci1;
                end
                // Untagged keeps the default-VLAN outer tag alone
            end
            default: begin
                // Normal port: own tag if present, else the default VLAN
                if (has_tag) begin
                    cls_next.outer_type = rx_hdr.type1;
                    cls_next.outer_tci = rx_hdr.tci1;
                end
            end
        endcase
        vmem = vt_mem_reg[cls_next.outer_tci[VW-1:0]];
        // Absent VLAN is discarded; non-member dropped only with filtering
        cls_next.drop = !vt_valid_reg[cls_next.outer_tci[VW-1:0]] ||
                        (has_tag && !vmem[rx_hdr.port] && filt_reg[rx_hdr.port]);
        // Lookup miss floods to outer VLAN members
        cls_next.flood = !rx_hdr.da_hit;
        cls_next.dest = rx_hdr.da_hit ? '0 : (vmem & ~(NPORT'(1) << rx_hdr.port));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cls_out <= '0;
            cls_valid <= 1'b0;
            rx_cnt_reg <= '0;
            drop_cnt_reg <= '0;
        end else if (clk_en) begin
            cls_valid <= rx_valid;
            if (rx_valid) begin
                cls_out <= cls_next;
                rx_cnt_reg <= rx_cnt_reg + 16'd1;
                if (cls_next.drop) begin
                    drop_cnt_reg <= drop_cnt_reg + 16'd1;
                end
            end
        end
    end

    // Egress tag decision by port membership and mode
    eg_res_t eg_next;
    always_comb begin
        vuntag = vt_untag_reg[eg_req.vid];
        eg_next.keep_inner = eg_req.two_tags;
        // Untagged member strips outer, tagged member keeps both
        eg_next.keep_outer = !vuntag[eg_req.port];
        if (tmode_reg[eg_req.port] == TUN_ACCESS) begin
            eg_next.keep_outer = 1'b0;
        end else begin
            unique case (mmode_reg[eg_req.port])
                MODE_ACCESS: begin
                    eg_next.keep_outer = 1'b0;
                    eg_next.keep_inner = 1'b0;
                end
                MODE_TRUNK: eg_next.keep_outer = 1'b1;
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eg_res <= '0;
            eg_res_valid <= 1'b0;
        end else if (clk_en) begin
            eg_res_valid <= eg_valid;
            if (eg_valid) begin
                eg_res <= eg_next;
            end
        end
    end

    // 10 ms tick shared by all GARP timers
    logic [19:0] tick_cnt_reg;
    logic tick;
    assign tick = tick_cnt_reg == 20'(TICK_CYC - 1);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_reg <= '0;
        end else if (clk_en) begin
            tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 20'd1;
        end
    end

    // GARP timers: centisecond counters that pulse and reload on the tick at which they stand at one
    logic [15:0] jt_reg [NPORT];
    logic [15:0] lt_reg [NPORT];
    logic [15:0] at_reg [NPORT];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NPORT; i++) begin
                jt_reg[i] <= RST_JOIN;
                lt_reg[i] <= RST_LEAVE;
                at_reg[i] <= RST_LEAVEALL;
            end
            join_expired <= '0;
            leave_expired <= '0;
            leaveall_expired <= '0;
        end else if (clk_en) begin
            for (int i = 0; i < NPORT; i++) begin
                join_expired[i] <= tick && jt_reg[i] == 16'd1;
                leave_expired[i] <= tick && lt_reg[i] == 16'd1;
                leaveall_expired[i] <= tick && at_reg[i] == 16'd1;
                if (tick) begin
                    jt_reg[i] <= (jt_reg[i] <= 16'd1) ? join_reg[i] : jt_reg[i] - 16'd1;
                    lt_reg[i] <= (lt_reg[i] <= 16'd1) ? leave_reg[i] : lt_reg[i] - 16'd1;
                    at_reg[i] <= (at_reg[i] <= 16'd1) ? lall_reg[i] : at_reg[i] - 16'd1;
                end
            end
        end
    end

    // Checks on the classifier and egress decisions and the port 0 join and leave-all timer ranges
    property p_access_outer;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && rx_valid && tmode_reg[rx_hdr.port] == TUN_ACCESS) |=>
            (cls_out.inner_valid && cls_out.outer_type == $past(ptpid));
    endproperty
    a_access_outer: assert property (p_access_outer) else $error("outer tag missing");

    property p_dummy;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && rx_valid && tmode_reg[rx_hdr.port] == TUN_ACCESS && !has_tag) |=>
            (cls_out.inner_type == STD_TPID && cls_out.inner_tci == DUMMY_TCI);
    endproperty
    a_dummy: assert property (p_dummy) else $error("dummy inner tag wrong");

    property p_prio;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && rx_valid && tmode_reg[rx_hdr.port] == TUN_ACCESS && has_tag) |=>
            (cls_out.outer_tci[15:13] == $past(rx_hdr.tci1[15:13]));
    endproperty
    a_prio: assert property (p_prio) else $error("priority not copied");

    property p_uplink_keep;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && rx_valid && tmode_reg[rx_hdr.port] == TUN_UPLINK && t1_port) |=>
            (cls_out.outer_tci == $past(rx_hdr.tci1));
    endproperty
    a_uplink_keep: assert property (p_uplink_keep) else $error("uplink tag added");

    property p_absent_drop;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && rx_valid && !vt_valid_reg[cls_next.outer_tci[VW-1:0]]) |=> cls_out.drop;
    endproperty
    a_absent_drop: assert property (p_absent_drop) else $error("absent VLAN not dropped");

    property p_flood;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && rx_valid && !rx_hdr.da_hit) |=> (cls_out.flood && cls_out.dest != '0 ||
            $past(vmem) == '0 || ($past(vmem) & ~(NPORT'(1) << $past(rx_hdr.port))) == '0);
    endproperty
    a_flood: assert property (p_flood) else $error("miss not flooded");

    property p_access_eg;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && eg_valid && tmode_reg[eg_req.port] == TUN_NORMAL &&
         mmode_reg[eg_req.port] == MODE_ACCESS) |=> (!eg_res.keep_outer && !eg_res.keep_inner);
    endproperty
    a_access_eg: assert property (p_access_eg) else $error("access port sent tag");

    property p_trunk_eg;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && eg_valid && tmode_reg[eg_req.port] == TUN_NORMAL &&
         mmode_reg[eg_req.port] == MODE_TRUNK) |=> eg_res.keep_outer;
    endproperty
    a_trunk_eg: assert property (p_trunk_eg) else $error("trunk port untagged");

    property p_join_range;
        @(posedge pclk) disable iff (!presetn)
        join_reg[0] >= JOIN_MIN && join_reg[0] <= JOIN_MAX &&
        lall_reg[0] >= LALL_MIN && lall_reg[0] <= LALL_MAX;
    endproperty
    a_join_range: assert property (p_join_range) else $error("timer out of range");
endmodule
`default_nettype wire

// File: dv/qinq_mac_model.sv
/* Port MAC model: hands parsed headers to the tag processor and takes
   back its classification. Assumes one clock and a result one cycle on. */
`timescale 1ns/100ps
`default_nettype none
module qinq_mac_model
    import qinq_pkg::*;
(
    input wire logic pclk,
    input wire logic cls_valid,
    input wire cls_t cls_out,
    output logic rx_valid,
    output rx_hdr_t rx_hdr
);
    cls_t got;
    logic got_ok;
    initial begin
        rx_valid = 1'b0;
        rx_hdr = '0;
    end
    // One header per call; released lines show the inverse, never a stale copy
    task automatic send(input rx_hdr_t h);
        rx_valid <= 1'b1;
        rx_hdr <= h;
        @(posedge pclk);
        rx_valid <= 1'b0;
        rx_hdr <= ~h;
        #1;
        got = cls_out;
        got_ok = cls_valid;
    endtask
endmodule
`default_nettype wire

// File: dv/qinq_tag_proc_tb.sv
/* Bench for the tag processor: APB setup, ingress and egress cases.
   Assumes the MAC model for ingress and the bench as egress scheduler. */
`timescale 1ns/100ps
`default_nettype none
module qinq_tag_proc_tb;
    import qinq_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, rx_valid, eg_valid, cls_valid, rdy, err, re;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    rx_hdr_t rx_hdr;
    cls_t cls_out;
    eg_req_t eg_req;
    eg_res_t eg_res;
    int fail_count = 0;
    int samples_checked = 0;
    qinq_tag_proc i_qinq_tag_proc(.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(rdy), .pslverr(err),
        .rx_valid(rx_valid), .rx_hdr(rx_hdr), .cls_out(cls_out),
        .cls_valid(cls_valid), .eg_valid(eg_valid), .eg_req(eg_req),
        .eg_res(eg_res), .eg_res_valid(), .join_expired(),
        .leave_expired(), .leaveall_expired());
    qinq_mac_model i_qinq_mac_model(.pclk(pclk), .cls_valid(cls_valid),
        .cls_out(cls_out), .rx_valid(rx_valid), .rx_hdr(rx_hdr));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // APB transfer; waits on pready under a bounded count
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (rdy !== 1'b1 && n < 20);
        if (n >= 20) chk(32'h0, 32'h1);
        rd = prdata;
        re = err;
        psel <= 1'b0;
        penable <= 1'b0;
        // Let one edge pass so a following setup never rewrites psel in this step
        @(posedge pclk);
    endtask
    task automatic rx(input logic [1:0] p, input logic [31:0] tag, input logic hit);
        i_qinq_mac_model.send({p, tag, 32'h0, hit});
        chk(i_qinq_mac_model.got_ok, 1);
    endtask
    task automatic eg(input logic [1:0] p, input logic [1:0] exp);
        eg_valid <= 1'b1;
        eg_req <= {p, 12'h005, 1'b1};
        @(posedge pclk);
        eg_valid <= 1'b0;
        #1;
        chk(eg_res, exp);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        #400000;
        fail_count++;
        conclude();
    end
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, eg_valid, paddr, pwdata, eg_req} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Reset values, unmapped access, timer clamp
        apb(0, 12'h100, 0); chk(rd, 32'h00010001);
        apb(0, 12'h104, 0); chk(rd, 32'h00008100);
        apb(0, 12'h108, 0); chk(rd, 32'h00000014);
        apb(0, 12'h10c, 0); chk(rd, 32'h03e8003c);
        apb(0, 12'h0fc, 0); chk(re, 1);
        apb(1, 12'h13c, 32'h00641388);
        apb(0, 12'h13c, 0); chk(rd, 32'h01f40bb8);
        // Software keeps 2 x join below leave below leave-all
        apb(1, 12'h138, 32'h00000032);
        apb(1, 12'h13c, 32'h03e800c8);
        apb(0, 12'h138, 0); chk(rd, 32'h00000032);
        apb(0, 12'h13c, 0); chk(rd, 32'h03e800c8);
        $display("registers done");
        // VLAN 5: ports 0,1 members, port 0 untagged; p0 access, p1 uplink tpid 9100
        apb(1, 12'h000, 32'h01031005);
        apb(1, 12'h100, 32'h00014005);
        apb(1, 12'h110, 32'h00018005);
        apb(1, 12'h114, 32'h00009100);
        apb(1, 12'h130, 32'h00001001); // Filter off, access member mode
        rx(0, 32'h08000000, 0);
        chk(cls_out.outer_type, 16'h8100);
        chk(cls_out.outer_tci, 16'h0005);
        chk({cls_out.inner_type, cls_out.inner_tci}, 32'h81000000);
        chk({cls_out.drop, cls_out.flood, cls_out.dest}, 6'b010010);
        rx(0, 32'h8100a00c, 1);
        chk({cls_out.outer_tci, cls_out.inner_tci}, 32'ha005a00c);
        rx(1, 32'h91000005, 1);
        chk({cls_out.drop, cls_out.inner_valid, cls_out.outer_tci}, 18'h00005);
        rx(1, 32'h81000007, 1);
        chk({cls_out.outer_type, cls_out.outer_tci}, 32'h91000005);
        chk(cls_out.inner_valid, 1);
        chk({cls_out.inner_type, cls_out.inner_tci}, 32'h81000007);
        rx(1, 32'h91000009, 1); chk(cls_out.drop, 1);
        rx(2, 32'h81000005, 1); chk(cls_out.drop, 1);
        rx(3, 32'h81000005, 1); chk(cls_out.drop, 0);
        $display("ingress done");
        apb(1, 12'h120, 32'h00012001); // Port 2 trunk member mode
        eg(0, 2'b01);
        eg(1, 2'b11);
        eg(3, 2'b00);
        eg(2, 2'b11);
        $display("egress done");
        conclude();
    end
endmodule
`default_nettype wire
